//--- src/tsss_pkg.sv
// Shared constants and types for both ends of the two-wire sensor link.
// Assumes a single 200 MHz clock on each end.
package tsss_pkg;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_BASE_NS = 25000;
	localparam int CONV_BASE_CYC = CONV_BASE_NS / CLK_PERIOD_NS;
	localparam int CONV_W = 20;
	// ---------------------------------------------------------------
	// Framing and addressing
	// ---------------------------------------------------------------
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] ACK_DONE = 4'h9;
	localparam logic [3:0] TYPE_SENSOR = 4'h9;
	localparam logic [3:0] TYPE_STORAGE = 4'hA;
	localparam logic [3:0] TYPE_PROTECT = 4'h6;
	localparam logic [7:0] PTR_TEMP = 8'h00;
	localparam logic [7:0] PTR_CFG = 8'h01;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam int CFG_RES_LO = 5;
	localparam logic [1:0] RES_MAX = 2'h3;
	localparam logic [1:0] SYNC_DEPTH = 2'h2;
	localparam logic [1:0] LOAD_DONE = 2'h3;
	localparam logic [11:0] SAMPLE_FULL = 12'hFFF;
	localparam logic [3:0] SAMPLE_PAD = 4'h0;
	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {DS_IDLE, DS_ADDR, DS_WRITE, DS_READ} tsss_dev_state_e;
	typedef enum logic [1:0] {TG_SENSOR, TG_STORAGE, TG_PROTECT} tsss_target_e;
	typedef enum logic [2:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP, HS_HOLD} tsss_host_state_e;
endpackage

//--- src/tsss_bus_if.sv
// Two-wire bus between the master and the sensor end.
// Both lines are open drain with a pull-up; levels resolve here.
`timescale 1ns/1ps
`default_nettype none
interface tsss_bus_if;
	logic hostSclOut;
	logic hostSclOe;
	logic hostSdaOut;
	logic hostSdaOe;
	logic devSdaOut;
	logic devSdaOe;
	logic scl;
	logic sda;

	assign scl = !(hostSclOe && !hostSclOut);
	assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

	modport dev (input scl, input sda, output devSdaOut, output devSdaOe);
	modport host (input scl, input sda, output hostSclOut, output hostSclOe, output hostSdaOut, output hostSdaOe);
endinterface
`default_nettype wire

//--- src/tsss_device.sv
// Sensor end: serial slave, address decode, result register, conversion timer.
// Assumes the bus lines and straps are asynchronous pins; tempSample is same-clock.
// Notes on behaviour
// R1: Sample on SCL rise, drive after fall
// R2: Bytes travel most significant bit first
// R3: Eight data clocks plus one acknowledge clock
// R4: Master clocks nine bits without gaps
// R5: Change SDA only while SCL low
// R6: SDA falling with SCL high starts
// R7: SDA rising with SCL high stops, idles
// R8: No limit on bytes per transfer
// R9: Bus idle only with both lines high
// R10: Ignore everything until a start arrives
// R11: Repeated start begins a new operation
// R12: Hold SDA low through the ack clock
// R13: Master NACK on read releases SDA
// R14: NACK writes to the read-only result
// R15: Sensor 1001, storage 1010, low bits strapped
// R16: Write-protect target answers at 0110 too
// R17: Address bits 7..1, bit 0 reads
// R18: Ack on match, NACK and idle otherwise
// R19: Convert continuously, overwrite result each time
// R20: Resolution field picks 9 to 12 bits
// R21: Conversion time doubles per extra bit
// R22: Reset reloads resolution from saved bits
// R23: Twelve-bit result spans -128 to +127
`timescale 1ns/1ps
`default_nettype none
module tsss_device
	import tsss_pkg::*;
#(
	parameter int ConvBaseCyc = CONV_BASE_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	tsss_bus_if.dev          bus,
	input  wire logic [2:0]  addressSelectPins,
	input  wire logic        savedResolutionHi,
	input  wire logic        savedResolutionLo,
	input  wire logic [11:0] tempSample,
	output logic      [15:0] tempResult,
	output logic      [1:0]  resolution,
	output logic             convDone,
	output logic             busBusy
);
	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic       sclMeta_r, sclSync_r, sclPrev_r;
	logic       sdaMeta_r, sdaSync_r, sdaPrev_r;
	logic [2:0] selMeta_r, selSync_r;
	logic [1:0] savedMeta_r, savedSync_r;

	always_ff @(posedge clk) begin
		sclMeta_r   <= bus.scl;
		sclSync_r   <= sclMeta_r;
		sclPrev_r   <= sclSync_r;
		sdaMeta_r   <= bus.sda;
		sdaSync_r   <= sdaMeta_r;
		sdaPrev_r   <= sdaSync_r;
		selMeta_r   <= addressSelectPins;
		selSync_r   <= selMeta_r;
		savedMeta_r <= {savedResolutionHi, savedResolutionLo};
		savedSync_r <= savedMeta_r;
	end

	// ---------------------------------------------------------------
	// Line events
	// ---------------------------------------------------------------
	wire sclRise = sclSync_r && !sclPrev_r; // R1
	wire sclFall = !sclSync_r && sclPrev_r;
	wire sclHigh = sclSync_r && sclPrev_r;
	wire startEv = sclHigh && sdaPrev_r && !sdaSync_r; // R6
	wire stopEv  = sclHigh && !sdaPrev_r && sdaSync_r; // R7

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	tsss_dev_state_e state_r;
	tsss_target_e    target_r;
	logic [3:0]      bitCnt_r;
	logic [7:0]      shift_r;
	logic [7:0]      pointer_r;
	logic            ptrSet_r;
	logic            byteIdx_r;
	logic            mNack_r;
	logic            sdaLow_r;
	logic [1:0]      resolution_r;
	logic [1:0]      loadWait_r;
	logic [CONV_W-1:0] convCnt_r;
	logic [15:0]     tempReg_r;
	logic            convDone_r;

	// ---------------------------------------------------------------
	// Address decode and data selection
	// ---------------------------------------------------------------
	wire  [3:0] typeId   = shift_r[7:4]; // R17
	wire        selMatch = shift_r[3:1] == selSync_r; // R15
	wire        rwRead   = shift_r[0]; // R17
	wire        hitSens  = selMatch && typeId == TYPE_SENSOR; // R15
	wire        hitStore = selMatch && typeId == TYPE_STORAGE; // R15
	wire        hitProt  = selMatch && typeId == TYPE_PROTECT; // R16
	wire        addrHit  = hitSens || hitStore || hitProt;
	wire  [7:0] cfgByte  = {6'h00, resolution_r} << CFG_RES_LO;
	wire  [7:0] tempByte = byteIdx_r ? tempReg_r[7:0] : tempReg_r[15:8];
	wire  [7:0] sensByte = pointer_r == PTR_TEMP ? tempByte : (pointer_r == PTR_CFG ? cfgByte : 8'h00);
	wire  [7:0] txByte   = target_r == TG_SENSOR ? sensByte : ERASED_BYTE;
	wire        txBit    = txByte[3'(BYTE_BITS - 4'h1 - bitCnt_r)]; // R2
	wire        sensWr   = target_r == TG_SENSOR && ptrSet_r;
	wire        wrOk     = !sensWr || pointer_r == PTR_CFG; // R14
	wire        ackSlot  = sclFall && bitCnt_r == BYTE_BITS; // R3
	wire        cfgWrite = state_r == DS_WRITE && ackSlot && sensWr && pointer_r == PTR_CFG;
	wire  [CONV_W-1:0] convLen  = CONV_W'(ConvBaseCyc) << resolution_r; // R21
	wire  [11:0] resMask = SAMPLE_FULL << (RES_MAX - resolution_r); // R20

	// ---------------------------------------------------------------
	// Serial protocol
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r   <= DS_IDLE;
			target_r  <= TG_SENSOR;
			bitCnt_r  <= 4'h0;
			shift_r   <= 8'h00;
			pointer_r <= PTR_TEMP;
			ptrSet_r  <= 1'b0;
			byteIdx_r <= 1'b0;
			mNack_r   <= 1'b0;
			sdaLow_r  <= 1'b0;
		end else if (startEv) begin // R6 R11
			state_r   <= DS_ADDR;
			bitCnt_r  <= 4'h0;
			ptrSet_r  <= 1'b0;
			byteIdx_r <= 1'b0;
			sdaLow_r  <= 1'b0;
		end else if (stopEv) begin // R7 R9
			state_r  <= DS_IDLE;
			sdaLow_r <= 1'b0;
		end else if (state_r != DS_IDLE) begin // R10
			if (sclRise) begin // R1
				bitCnt_r <= bitCnt_r + 4'h1;
				if (bitCnt_r < BYTE_BITS)
					shift_r <= {shift_r[6:0], sdaSync_r}; // R2
				else
					mNack_r <= sdaSync_r; // R13
			end else if (ackSlot) begin // R5 R12
				unique case (state_r)
					DS_ADDR: begin
						if (addrHit) begin // R18
							sdaLow_r <= 1'b1;
							target_r <= hitSens ? TG_SENSOR : (hitStore ? TG_STORAGE : TG_PROTECT);
						end else begin
							state_r <= DS_IDLE; // R18
						end
					end
					DS_WRITE: begin
						sdaLow_r <= wrOk; // R14
						if (target_r == TG_SENSOR && !ptrSet_r) begin
							pointer_r <= shift_r;
							ptrSet_r  <= 1'b1;
						end
					end
					default: begin
						sdaLow_r  <= 1'b0;
						byteIdx_r <= !byteIdx_r;
					end
				endcase
			end else if (sclFall && bitCnt_r == ACK_DONE) begin // R3 R8
				bitCnt_r <= 4'h0;
				unique case (state_r)
					DS_ADDR: begin
						state_r  <= rwRead ? DS_READ : DS_WRITE;
						sdaLow_r <= rwRead && !txByte[7];
					end
					DS_WRITE: sdaLow_r <= 1'b0;
					default: begin
						if (mNack_r) begin // R13
							state_r  <= DS_IDLE;
							sdaLow_r <= 1'b0;
						end else begin
							sdaLow_r <= !txByte[7];
						end
					end
				endcase
			end else if (sclFall && state_r == DS_READ) begin // R1 R5
				sdaLow_r <= !txBit;
			end
		end
	end

	// ---------------------------------------------------------------
	// Resolution: restored from saved bits once straps are synced
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			loadWait_r   <= 2'h0;
			resolution_r <= RES_MAX;
		end else begin
			if (loadWait_r != LOAD_DONE)
				loadWait_r <= loadWait_r + 2'h1;
			if (loadWait_r == SYNC_DEPTH)
				resolution_r <= savedSync_r; // R22
			else if (cfgWrite)
				resolution_r <= shift_r[CFG_RES_LO +: 2]; // R20
		end
	end

	// ---------------------------------------------------------------
	// Continuous conversion
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			convCnt_r  <= '0;
			tempReg_r  <= 16'h0000;
			convDone_r <= 1'b0;
		end else begin
			convDone_r <= 1'b0;
			if (convCnt_r >= convLen - CONV_W'(1)) begin // R19 R21
				convCnt_r  <= '0;
				tempReg_r  <= {tempSample & resMask, SAMPLE_PAD}; // R20 R23
				convDone_r <= 1'b1;
			end else begin
				convCnt_r <= convCnt_r + CONV_W'(1);
			end
		end
	end

	assign bus.devSdaOut = 1'b0;
	assign bus.devSdaOe  = sdaLow_r;
	assign tempResult    = tempReg_r;
	assign resolution    = resolution_r;
	assign convDone      = convDone_r;
	assign busBusy       = state_r != DS_IDLE;
endmodule
`default_nettype wire

//--- src/tsss_host.sv
// Master end: issues start, address, data bytes, stop or repeated start.
// Assumes a command port on the same clock; SDA comes back as a pin.
`timescale 1ns/1ps
`default_nettype none
module tsss_host
	import tsss_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	tsss_bus_if.host        bus,
	input  wire logic       cmdValid,
	output logic            cmdReady,
	input  wire logic [6:0] cmdAddr,
	input  wire logic       cmdRead,
	input  wire logic [7:0] cmdCount,
	input  wire logic       cmdHold,
	input  wire logic [7:0] wrData,
	output logic            wrTake,
	output logic      [7:0] rdData,
	output logic            rdValid,
	output logic            done,
	output logic            nackSeen
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	tsss_host_state_e state_r;
	logic [7:0] qCnt_r;
	logic [1:0] qtr_r;
	logic [3:0] bitCnt_r;
	logic [7:0] tx_r, rx_r, left_r, rdData_r;
	logic       read_r, hold_r, addrPh_r, devNack_r;
	logic       sclRel_r, sdaRel_r;
	logic       sdaMeta_r, sdaSync_r;
	logic       done_r, rdValid_r, wrTake_r, nack_r;

	wire tick     = qCnt_r == 8'(QTR_CYC - 1);
	wire devAcks  = addrPh_r || !read_r;
	wire lastByte = left_r == 8'h01;
	wire dataBit  = bitCnt_r < BYTE_BITS;

	always_ff @(posedge clk) begin
		sdaMeta_r <= bus.sda;
		sdaSync_r <= sdaMeta_r;
	end

	// ---------------------------------------------------------------
	// Bit sequencer, four quarters per SCL period
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= HS_IDLE;
			qCnt_r <= 8'h00;
			qtr_r <= 2'h0;
			bitCnt_r <= 4'h0;
			tx_r <= 8'h00;
			rx_r <= 8'h00;
			left_r <= 8'h00;
			rdData_r <= 8'h00;
			{read_r, hold_r, addrPh_r, devNack_r} <= 4'h0;
			sclRel_r <= 1'b1;
			sdaRel_r <= 1'b1;
			{done_r, rdValid_r, wrTake_r, nack_r} <= 4'h0;
		end else begin
			{done_r, rdValid_r, wrTake_r} <= 3'h0;
			qCnt_r <= tick ? 8'h00 : qCnt_r + 8'h01;
			if (tick)
				qtr_r <= qtr_r + 2'h1;
			unique case (state_r)
				HS_IDLE, HS_HOLD: begin
					qCnt_r <= 8'h00;
					qtr_r <= 2'h0;
					if (cmdValid) begin
						state_r <= HS_START;
						tx_r <= {cmdAddr, cmdRead};
						{read_r, hold_r, addrPh_r, nack_r} <= {cmdRead, cmdHold, 2'b10};
						left_r <= cmdCount;
						bitCnt_r <= 4'h0;
						sdaRel_r <= 1'b1;
					end
				end
				HS_START: if (tick) begin // R6 R11
					unique case (qtr_r)
						2'h0: sclRel_r <= 1'b1;
						2'h1: sdaRel_r <= 1'b0;
						2'h2: sclRel_r <= 1'b0;
						default: state_r <= HS_BIT;
					endcase
				end
				HS_BIT: if (tick) begin // R4
					unique case (qtr_r)
						2'h0: sdaRel_r <= dataBit ? (read_r && !addrPh_r) || tx_r[7] : devAcks || lastByte; // R2 R5 R13
						2'h1: sclRel_r <= 1'b1;
						2'h2: begin
							if (dataBit)
								rx_r <= {rx_r[6:0], sdaSync_r};
							else
								devNack_r <= devAcks && sdaSync_r; // R12
						end
						default: begin
							sclRel_r <= 1'b0;
							bitCnt_r <= dataBit ? bitCnt_r + 4'h1 : 4'h0;
							tx_r <= {tx_r[6:0], 1'b0};
							if (!dataBit) begin // R3
								if (!addrPh_r) begin
									left_r <= left_r - 8'h01;
									rdData_r <= rx_r;
									rdValid_r <= read_r;
								end
								addrPh_r <= 1'b0;
								if (devNack_r) begin
									nack_r <= 1'b1;
									state_r <= HS_STOP;
								end else if ((addrPh_r && left_r == 8'h00) || (!addrPh_r && lastByte)) begin
									state_r <= hold_r ? HS_HOLD : HS_STOP; // R11
									done_r <= hold_r;
								end else if (!read_r) begin
									tx_r <= wrData;
									wrTake_r <= 1'b1;
								end
							end
						end
					endcase
				end
				HS_STOP: if (tick) begin // R7 R9
					unique case (qtr_r)
						2'h0: sdaRel_r <= 1'b0;
						2'h1: sclRel_r <= 1'b1;
						2'h2: sdaRel_r <= 1'b1;
						default: begin
							state_r <= HS_IDLE;
							done_r <= 1'b1;
						end
					endcase
				end
				default: state_r <= HS_IDLE;
			endcase
		end
	end

	assign bus.hostSclOut = 1'b0;
	assign bus.hostSclOe  = !sclRel_r;
	assign bus.hostSdaOut = 1'b0;
	assign bus.hostSdaOe  = !sdaRel_r;
	assign cmdReady       = state_r == HS_IDLE || state_r == HS_HOLD;
	assign wrTake         = wrTake_r;
	assign rdData         = rdData_r;
	assign rdValid        = rdValid_r;
	assign done           = done_r;
	assign nackSeen       = nack_r;
endmodule
`default_nettype wire

//--- test/tsss_chk.sv
// Bus-side checker for the two-wire link between the master and sensor ends.
// Assumes the interface's resolved lines and the device SDA drive enable, one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module tsss_chk
	import tsss_pkg::*;
#(
	parameter logic [2:0] Sel = 3'h0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic devSdaOe
);
	// ---------------------------------------------------------------
	// Frame tracking
	// ---------------------------------------------------------------
	logic       sclD_r;
	logic       sdaD_r;
	logic       inFrame_r;
	logic       pastAddr_r;
	logic [3:0] bitCnt_r;
	logic [7:0] shift_r;
	wire        startEv   = scl && sclD_r && sdaD_r && !sda;
	wire        stopEv    = scl && sclD_r && !sdaD_r && sda;
	wire        sclRise   = scl && !sclD_r;
	wire        lastBit   = (bitCnt_r == BYTE_BITS);
	wire        ackRise   = sclRise && inFrame_r && lastBit;
	wire        typeOk    = (shift_r[7:4] == TYPE_SENSOR) || (shift_r[7:4] == TYPE_STORAGE)
		|| (shift_r[7:4] == TYPE_PROTECT);
	wire        addrMatch = typeOk && (shift_r[3:1] == Sel);

	always_ff @(posedge clk) begin
		sclD_r <= scl;
		sdaD_r <= sda;
		if (rst || startEv) begin
			inFrame_r  <= !rst;
			bitCnt_r   <= 4'h0;
			pastAddr_r <= 1'b0;
		end else if (stopEv) begin
			inFrame_r <= 1'b0;
		end else if (sclRise && inFrame_r) begin
			shift_r    <= {shift_r[6:0], sda};
			bitCnt_r   <= lastBit ? 4'h0 : bitCnt_r + 4'h1;
			pastAddr_r <= pastAddr_r || lastBit;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_DEV_AFTER_FALL: assert property ($changed(devSdaOe) |-> !scl && !$past(scl) && !$past(scl, 2))
		else $error("device SDA changed without a preceding SCL fall");
	AST_DEV_STEADY_HIGH: assert property (scl && $past(scl) |-> $stable(devSdaOe))
		else $error("device SDA changed while SCL high");
	AST_QUIET_UNTIL_START: assert property (!inFrame_r |-> !devSdaOe)
		else $error("device drove SDA outside a frame");
	AST_STOP_RELEASE: assert property (stopEv |=> !devSdaOe [*8])
		else $error("device drove SDA after stop");
	AST_BUS_IDLE: assert property (!inFrame_r && !startEv |-> scl && sda)
		else $error("bus not idle outside a frame");
	AST_ACK_WHOLE: assert property (ackRise && devSdaOe |-> $past(devSdaOe, 100) ##1 devSdaOe [*8])
		else $error("acknowledge not held across the ninth clock");
	AST_MASTER_NACK: assert property (ackRise && pastAddr_r && sda |=> !devSdaOe [*8] ##252 !devSdaOe)
		else $error("device kept SDA after a high acknowledge slot");
	AST_NO_GAP: assert property (sclRise && inFrame_r && bitCnt_r != 4'h0 && !lastBit |-> ##[1:600] sclRise)
		else $error("SCL gap inside a nine-clock group");
	AST_ADDR_DECODE: assert property (ackRise && !pastAddr_r |-> devSdaOe == addrMatch)
		else $error("address acknowledge does not match decode");
endmodule
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench: master end and sensor end joined by the bus interface.
// Assumes the package timing constants and a shortened conversion base count.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tsss_pkg::*;
	localparam logic [2:0] SEL = 3'h5;
	localparam int LIMIT = 40000;
	localparam int CONV_SIM = 20;
	logic        clk;
	logic        rst;
	logic        cmdValid;
	logic        cmdReady;
	logic [6:0]  cmdAddr;
	logic        cmdRead;
	logic [7:0]  cmdCount;
	logic        cmdHold;
	logic [7:0]  wrData;
	logic        wrTake;
	logic [7:0]  rdData;
	logic        rdValid;
	logic        done;
	logic        nackSeen;
	logic [15:0] tempResult;
	logic [1:0]  resolution;
	logic        convDone;
	logic        busBusy;
	logic [1:0]  saved;
	logic [7:0]  rdq [0:3];
	int          failures;
	int          comparisons;
	int          p1;
	int          p3;
	int          p2;

	tsss_bus_if busIf ();
	tsss_device #(.ConvBaseCyc(CONV_SIM)) tsss_device_inst (.clk(clk), .rst(rst), .bus(busIf.dev),
		.addressSelectPins(SEL), .savedResolutionHi(saved[1]), .savedResolutionLo(saved[0]),
		.tempSample(12'hC93), .tempResult(tempResult), .resolution(resolution),
		.convDone(convDone), .busBusy(busBusy));
	tsss_host tsss_host_inst (.clk(clk), .rst(rst), .bus(busIf.host), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .cmdAddr(cmdAddr), .cmdRead(cmdRead), .cmdCount(cmdCount),
		.cmdHold(cmdHold), .wrData(wrData), .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid),
		.done(done), .nackSeen(nackSeen));
	tsss_chk #(.Sel(SEL)) tsss_chk_inst (.clk(clk), .rst(rst), .scl(busIf.scl), .sda(busIf.sda),
		.devSdaOe(busIf.devSdaOe));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic wrap_up();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic do_cmd(input logic [6:0] a, input logic r, input logic [7:0] n, input logic h,
		input logic [7:0] b0, input logic [7:0] b1);
		int i;
		int k;
		k = 0;
		for (i = 0; i < LIMIT && cmdReady !== 1'b1; i++) @(negedge clk);
		if (i == LIMIT) begin
			failures++;
			wrap_up();
		end
		{cmdValid, cmdAddr, cmdRead, cmdCount, cmdHold, wrData} = {1'b1, a, r, n, h, b0};
		@(negedge clk);
		cmdValid = 1'b0;
		for (i = 0; i < LIMIT; i++) begin
			@(negedge clk);
			if (wrTake === 1'b1) wrData = b1;
			if (rdValid === 1'b1 && k < 4) begin
				rdq[k] = rdData;
				k++;
			end
			if (done === 1'b1) break;
		end
		if (i == LIMIT) begin
			failures++;
			wrap_up();
		end
	endtask

	task automatic measure(output int p);
		int i;
		p = 0;
		for (i = 0; i < 2000 && convDone !== 1'b1; i++) @(negedge clk);
		if (i == 2000) begin
			failures++;
			wrap_up();
		end
		@(negedge clk);
		for (i = 0; i < 2000 && convDone !== 1'b1; i++) @(negedge clk);
		p = i;
		if (i == 2000) begin
			failures++;
			wrap_up();
		end
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic scn_reset_restore();
		measure(p1);
		check({14'h0, resolution}, 16'h0001);
		check(16'(p1), 16'((CONV_SIM << 1) - 1));
		check(tempResult, 16'hC900);
		check({15'h0, busBusy}, 16'h0000);
	endtask

	task automatic scn_config_write();
		do_cmd({TYPE_SENSOR, SEL}, 1'b0, 8'h02, 1'b1, PTR_CFG, 8'h60);
		check({15'h0, nackSeen}, 16'h0000);
		check({14'h0, resolution}, 16'h0003);
		do_cmd({TYPE_SENSOR, SEL}, 1'b1, 8'h01, 1'b0, 8'h00, 8'h00);
		check({15'h0, nackSeen}, 16'h0000);
		check({8'h0, rdq[0]}, 16'h0060);
		measure(p3);
		check(16'(p3 > p1), 16'h0001);
		check(16'(p3), 16'((CONV_SIM << 3) - 1));
		check(tempResult, 16'hC930);
	endtask

	task automatic scn_readonly_and_miss();
		do_cmd({TYPE_SENSOR, SEL}, 1'b0, 8'h02, 1'b0, PTR_TEMP, 8'h12);
		check({15'h0, nackSeen}, 16'h0001);
		check({14'h0, resolution}, 16'h0003);
		do_cmd({TYPE_SENSOR, SEL ^ 3'h1}, 1'b0, 8'h00, 1'b0, 8'h00, 8'h00);
		check({15'h0, nackSeen}, 16'h0001);
		check({15'h0, busBusy}, 16'h0000);
	endtask

	task automatic scn_other_targets();
		do_cmd({TYPE_PROTECT, SEL}, 1'b0, 8'h00, 1'b0, 8'h00, 8'h00);
		check({15'h0, nackSeen}, 16'h0000);
		do_cmd({TYPE_STORAGE, SEL}, 1'b1, 8'h01, 1'b0, 8'h00, 8'h00);
		check({15'h0, nackSeen}, 16'h0000);
		check({8'h0, rdq[0]}, {8'h0, ERASED_BYTE});
	endtask

	task automatic scn_repeated_start();
		do_cmd({TYPE_SENSOR, SEL}, 1'b0, 8'h01, 1'b1, PTR_TEMP, 8'h00);
		check({15'h0, busBusy}, 16'h0001);
		do_cmd({TYPE_SENSOR, SEL}, 1'b1, 8'h02, 1'b0, 8'h00, 8'h00);
		check({15'h0, nackSeen}, 16'h0000);
		check({rdq[0], rdq[1]}, 16'hC930);
		check({15'h0, busBusy}, 16'h0000);
	endtask

	task automatic scn_second_reset();
		saved = 2'h2;
		rst = 1'b1;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		check({15'h0, busBusy}, 16'h0000);
		measure(p2);
		check({14'h0, resolution}, 16'h0002);
		check(16'(p2), 16'((CONV_SIM << 2) - 1));
		check(tempResult, 16'hC920);
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		{rst, cmdValid, cmdAddr, cmdRead, cmdCount, cmdHold, wrData} = {1'b1, 26'h0};
		failures = 0;
		saved = 2'h1;
		comparisons = 0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		scn_reset_restore();
		scn_config_write();
		scn_readonly_and_miss();
		scn_other_targets();
		scn_repeated_start();
		scn_second_reset();
		wrap_up();
	end
endmodule
`default_nettype wire
